// ==== core/rcm_mode_ctrl.v ====
// Run/console mode controller with power-up self-test
`timescale 1ns/1ps
`include "rcm_ctrl_regs.vh"
module rcm_mode_ctrl
(
    // Clock, reset, enable
    input wire clk_in,
    input wire rst_n_in,
    input wire ce_in,
    // Power events and options
    input wire power_up_in,
    input wire power_fail_in,
    input wire battery_present_in,
    input wire panel_lock_in,
    // Serial interface events
    input wire break_rx_in,
    input wire term_ok_in,
    // Fetch request from processor core
    input wire fetch_req_in,
    input wire [15:0] fetch_addr_in,
    input wire [15:0] wr_data_in,
    input wire wr_req_in,
    // Buses
    input wire [15:0] memory_return_bus_in,
    input wire [15:0] serial_rx_data_in,
    output reg [15:0] processor_result_bus_out,
    output reg [15:0] processor_input_bus_out,
    output reg [15:0] fetch_data_out,
    // Memory and ROM strobes
    output reg mem_rd_out,
    output reg mem_wr_out,
    output reg rom_rd_out,
    output reg scr_wr_out,
    // Status
    output reg console_mode_out,
    output reg run_mode_out,
    output reg self_test_out,
    output reg self_test_fail_out,
    output reg prog_interrupt_out
);

// --------------------------------------------------------------
// Input synchronisers
// --------------------------------------------------------------
reg [5:0] sync1_r;
reg [5:0] sync2_r;
reg brk_prev_r;
wire pu_s = sync2_r[0];
wire pf_s = sync2_r[1];
wire bat_s = sync2_r[2];
wire lock_s = sync2_r[3];
wire brk_s = sync2_r[4];
wire tok_s = sync2_r[5];
wire brk_rise = brk_s & ~brk_prev_r;

// Two flops on each power, panel-lock and serial event input
always @(posedge clk_in or negedge rst_n_in)
begin
    if (!rst_n_in)
    begin
        sync1_r <= 6'h00;
        sync2_r <= 6'h00;
        brk_prev_r <= 1'b0;
    end
    else if (ce_in)
    begin
        sync1_r <= {term_ok_in, break_rx_in, panel_lock_in, battery_present_in, power_fail_in, power_up_in};
        sync2_r <= sync1_r;
        brk_prev_r <= brk_s;
    end
end

// --------------------------------------------------------------
// Mode and self-test sequencer
// --------------------------------------------------------------
reg [2:0] state_r;
reg [2:0] state_nxt;
reg [14:0] tst_addr_r;
reg tst_wr_r;
reg fail_r;
reg rd_chk_r;
reg [14:0] rd_addr_r;
wire mem_last = (tst_addr_r == {`RCM_MEM_AW{1'b1}});
wire pf_restart = pf_s & ~bat_s;
// Power-up, or power fail with no battery present, pins the sequencer in its idle state
wire restart = pu_s | pf_restart;
// Monitor start command: a console write with the start bit set
wire run_start = fetch_req_in & wr_req_in & fetch_addr_in[`RCM_START_BIT];

// Next state, exactly one mode outside test
always @*
begin
    state_nxt = state_r;
    case (state_r)
        `RCM_ST_IDLE: state_nxt = `RCM_ST_CPU;
        `RCM_ST_CPU: state_nxt = `RCM_ST_MEM;
        `RCM_ST_MEM: if (mem_last && !tst_wr_r) state_nxt = `RCM_ST_TERM;
        `RCM_ST_TERM: if (tok_s) state_nxt = `RCM_ST_CONSOLE;
        `RCM_ST_CONSOLE: if (run_start) state_nxt = `RCM_ST_RUN;
        `RCM_ST_RUN: if (brk_rise && !lock_s) state_nxt = `RCM_ST_CONSOLE;
        default: state_nxt = `RCM_ST_IDLE;
    endcase
    if (restart)
        state_nxt = `RCM_ST_IDLE;
end

// State and memory test walker
always @(posedge clk_in or negedge rst_n_in)
begin
    if (!rst_n_in)
    begin
        state_r <= `RCM_ST_IDLE;
        tst_addr_r <= 15'h0000;
        tst_wr_r <= 1'b1;
        fail_r <= 1'b0;
        rd_chk_r <= 1'b0;
        rd_addr_r <= 15'h0000;
    end
    else if (ce_in)
    begin
        state_r <= state_nxt;
        // Read-back data arrives one cycle after its address went out
        rd_chk_r <= (state_r == `RCM_ST_MEM) && !tst_wr_r;
        rd_addr_r <= tst_addr_r;
        if (rd_chk_r && memory_return_bus_in != (`RCM_TEST_PATTERN ^ {1'b0, rd_addr_r}))
            fail_r <= 1'b1;
        // A fresh test starts with a clean flag, so idle clears last
        if (state_r == `RCM_ST_IDLE)
        begin
            tst_addr_r <= 15'h0000;
            tst_wr_r <= 1'b1;
            fail_r <= 1'b0;
        end
        else if (state_r == `RCM_ST_MEM)
        begin
            // Write whole array, then read it back
            if (mem_last)
                tst_wr_r <= 1'b0;
            tst_addr_r <= tst_addr_r + 15'h0001;
        end
    end
end

// --------------------------------------------------------------
// Bus steering
// --------------------------------------------------------------
// Test flag follows the next state so it never overlaps console mode
wire in_test = (state_nxt == `RCM_ST_CPU) || (state_nxt == `RCM_ST_MEM) || (state_nxt == `RCM_ST_TERM);

// Registered outputs
always @(posedge clk_in or negedge rst_n_in)
begin
    if (!rst_n_in)
    begin
        processor_result_bus_out <= 16'h0000;
        processor_input_bus_out <= 16'h0000;
        fetch_data_out <= 16'h0000;
        mem_rd_out <= 1'b0;
        mem_wr_out <= 1'b0;
        rom_rd_out <= 1'b0;
        scr_wr_out <= 1'b0;
        console_mode_out <= 1'b0;
        run_mode_out <= 1'b0;
        self_test_out <= 1'b1;
        self_test_fail_out <= 1'b0;
        prog_interrupt_out <= 1'b0;
    end
    else if (ce_in)
    begin
        console_mode_out <= (state_nxt == `RCM_ST_CONSOLE);
        run_mode_out <= (state_nxt == `RCM_ST_RUN);
        self_test_out <= in_test || (state_nxt == `RCM_ST_IDLE);
        self_test_fail_out <= fail_r;
        // Pulse only when the break really moves us to console
        prog_interrupt_out <= (state_r == `RCM_ST_RUN) && (state_nxt == `RCM_ST_CONSOLE);
        processor_input_bus_out <= serial_rx_data_in;
        fetch_data_out <= memory_return_bus_in;
        mem_rd_out <= 1'b0;
        mem_wr_out <= 1'b0;
        rom_rd_out <= 1'b0;
        scr_wr_out <= 1'b0;
        if (state_r == `RCM_ST_MEM)
        begin
            processor_result_bus_out <= tst_wr_r ? (`RCM_TEST_PATTERN ^ {1'b0, tst_addr_r}) : {1'b0, tst_addr_r};
            mem_wr_out <= tst_wr_r;
            mem_rd_out <= ~tst_wr_r;
        end
        else if (state_r == `RCM_ST_RUN && fetch_req_in && !restart)
        begin
            processor_result_bus_out <= wr_req_in ? wr_data_in : {1'b0, fetch_addr_in[`RCM_MEM_AW-1:0]};
            mem_rd_out <= ~wr_req_in;
            mem_wr_out <= wr_req_in;
        end
        else if (state_r == `RCM_ST_CONSOLE && fetch_req_in && !restart && !fetch_addr_in[`RCM_START_BIT])
        begin
            // Scratch RAM sits just above the 512-word ROM window
            if (fetch_addr_in[`RCM_ROM_AW])
            begin
                processor_result_bus_out <= wr_req_in ? wr_data_in : {12'h000, fetch_addr_in[`RCM_SCR_AW-1:0]};
                scr_wr_out <= wr_req_in;
            end
            else
            begin
                processor_result_bus_out <= {7'h00, fetch_addr_in[`RCM_ROM_AW-1:0]};
                rom_rd_out <= 1'b1;
            end
        end
    end
end

endmodule

// ==== shared/rcm_ctrl_regs.vh ====
// Constants for the run/console mode controller
`ifndef RCM_CTRL_REGS_VH
`define RCM_CTRL_REGS_VH
`define RCM_MEM_AW 15
`define RCM_ROM_AW 9
`define RCM_ROM_WORDS 512
`define RCM_SCR_AW 4
`define RCM_SCR_WORDS 16
`define RCM_START_BIT 15
`define RCM_DW 16
`define RCM_ST_IDLE 3'h0
`define RCM_ST_CPU 3'h1
`define RCM_ST_MEM 3'h2
`define RCM_ST_TERM 3'h3
`define RCM_ST_CONSOLE 3'h4
`define RCM_ST_RUN 3'h5
`define RCM_TEST_PATTERN 16'ha5c3
`endif

// ==== verification/rcm_mode_ctrl_sva.sv ====
// Port checker for the run/console mode controller
`timescale 1ns/1ps
module rcm_mode_sva (
    // Clock, reset and inputs
    input wire clk_in, rst_n_in, ce_in, panel_lock_in,
    input wire [15:0] memory_return_bus_in, serial_rx_data_in,
    // Outputs under watch
    input wire [15:0] processor_result_bus_out, processor_input_bus_out, fetch_data_out,
    input wire mem_rd_out, rom_rd_out, console_mode_out, run_mode_out, self_test_out, prog_interrupt_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_excl; !(console_mode_out && run_mode_out); endproperty
    a_excl: assert property (p_excl) else $error("two modes at once");
    property p_st; self_test_out |-> !console_mode_out && !rom_rd_out; endproperty
    a_st: assert property (p_st) else $error("console during test");
    property p_mem; console_mode_out && $past(console_mode_out) |-> !mem_rd_out; endproperty
    a_mem: assert property (p_mem) else $error("memory read in console");
    property p_rom; rom_rd_out |-> processor_result_bus_out[15:9] == 7'h00; endproperty
    a_rom: assert property (p_rom) else $error("wide monitor address");
    property p_fd; $past(ce_in) && $past(rst_n_in) |-> fetch_data_out == $past(memory_return_bus_in); endproperty
    a_fd: assert property (p_fd) else $error("return data lost");
    property p_ib; $past(ce_in) && $past(rst_n_in) |-> processor_input_bus_out == $past(serial_rx_data_in); endproperty
    a_ib: assert property (p_ib) else $error("serial data lost");
    property p_irq; prog_interrupt_out |-> console_mode_out && $past(run_mode_out); endproperty
    a_irq: assert property (p_irq) else $error("stray interrupt");
    property p_lock; $past(panel_lock_in, 3) |-> !prog_interrupt_out; endproperty
    a_lock: assert property (p_lock) else $error("break while locked");
endmodule
bind rcm_mode_ctrl rcm_mode_sva u_sva (.*);

// ==== verification/rcm_term_model.sv ====
// Serial terminal stand-in
`timescale 1ns/1ps
module rcm_term_model (
    input wire clk_in, send_brk_in,
    output reg break_rx_out, term_ok_out,
    output reg [15:0] rx_data_out
);
    initial {break_rx_out, term_ok_out, rx_data_out} = 18'h00001;
    // New data every cycle so a stale copy shows
    always @(posedge clk_in)
    begin
        rx_data_out <= #1 rx_data_out * 16'h0005 + 16'h3a1b;
        break_rx_out <= #1 send_brk_in;
        term_ok_out <= #1 1'b1;
    end
endmodule

// ==== verification/tb.sv ====
// Bench for the run/console mode controller
`timescale 1ns/1ps
`include "rcm_ctrl_regs.vh"
module tb;
    reg clk_in = 0, rst_n_in = 0, ce_in = 1, pu = 0, pf = 0, bat = 1, lock = 0, brk = 0, fr = 0, wr = 0;
    reg [15:0] fa = 0, rdv = 0, nrom = 0, nmem = 0, nscr = 0, nirq = 0, last_rb = 0;
    wire brx, tok, mrd, mwr, rrd, swr, con, run, st, stf, irq;
    wire [15:0] rxd, rb, ib, fd, memory_return_bus;
    // Memory stand-in: good read-back word while a read stands, else a moving word
    assign memory_return_bus = mrd ? (`RCM_TEST_PATTERN ^ rb) : rdv;
    integer err_total = 0, comparisons = 0, cyc = 0;
    always #4 clk_in = ~clk_in;
    rcm_term_model term (.clk_in(clk_in), .send_brk_in(brk), .break_rx_out(brx), .term_ok_out(tok),
        .rx_data_out(rxd));
    rcm_mode_ctrl dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .power_up_in(pu),
        .power_fail_in(pf), .battery_present_in(bat), .panel_lock_in(lock), .break_rx_in(brx),
        .term_ok_in(tok), .fetch_req_in(fr), .fetch_addr_in(fa), .wr_data_in(16'hbeef), .wr_req_in(wr),
        .memory_return_bus_in(memory_return_bus), .serial_rx_data_in(rxd), .processor_result_bus_out(rb),
        .processor_input_bus_out(ib), .fetch_data_out(fd), .mem_rd_out(mrd), .mem_wr_out(mwr),
        .rom_rd_out(rrd), .scr_wr_out(swr), .console_mode_out(con), .run_mode_out(run),
        .self_test_out(st), .self_test_fail_out(stf), .prog_interrupt_out(irq));
    // Return data, console strobe counts and the hang limit
    always @(posedge clk_in)
    begin
        if (rst_n_in) rdv <= #1 rdv + 16'h0101;
        if (con) {nrom, nmem, nscr} <= {nrom + rrd, nmem + mrd, nscr + swr};
        nirq <= nirq + irq;
        if (rrd) last_rb <= rb;
        cyc = cyc + 1;
        if (cyc == 90000)
        begin
            err_total = err_total + 1;
            test_done;
        end
    end
    task step(input integer n); begin repeat (n) @(posedge clk_in); #1; end endtask
    task chk(input [15:0] got, input [15:0] exp);
    begin
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    end
    endtask
    task test_done;
    begin
        if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    task t_test;
    begin
        chk({st, con, run, irq}, 4'h8);
        rst_n_in = 1;
        fr = 1;
        step(4);
        chk({rrd, swr}, 2'h0);
        fr = 0;
        while (con !== 1'b1 && cyc < 80000) step(1);
        chk({st, con, run}, 3'h2);
        chk(stf, 16'h0000);
    end
    endtask
    task t_rom;
    begin
        {fr, fa} = 17'h101ff;
        step(1);
        fa = 16'h0001;
        step(1);
        fr = 0;
        step(1);
        ce_in = 0;
        {fr, fa} = 17'h10005;
        step(3);
        {fr, ce_in} = 2'h1;
        step(3);
        chk(nrom, 16'h0002);
        chk(last_rb, 16'h0001);
        chk(nmem, 16'h0000);
    end
    endtask
    task t_scr;
    begin
        {fr, wr, fa} = 18'h3020f;
        step(1);
        {fr, wr} = 2'h0;
        step(3);
        chk(nscr, 16'h0001);
    end
    endtask
    task t_brk;
    begin
        {fr, wr, fa} = 18'h38000;
        step(1);
        {fr, wr} = 2'h0;
        chk({con, run, swr}, 3'h2);
        {fr, fa} = 17'h11234;
        step(1);
        fr = 0;
        chk({mrd, rrd}, 2'h2);
        chk(rb, 16'h1234);
        lock = 1;
        step(4);
        brk = 1;
        step(8);
        chk({con, run}, 2'h1);
        chk(nirq, 16'h0000);
        brk = 0;
        step(4);
        lock = 0;
        step(4);
        brk = 1;
        step(8);
        chk({con, run}, 2'h2);
        chk(nirq, 16'h0001);
        brk = 0;
    end
    endtask
    task t_pf;
    begin
        pf = 1;
        step(6);
        chk({st, con}, 2'h1);
        pu = 1;
        step(6);
        chk({st, con}, 2'h2);
        pu = 0;
        step(8);
        chk({st, mwr}, 2'h3);
        bat = 0;
        step(6);
        chk({st, mwr}, 2'h2);
    end
    endtask
    initial
    begin
        step(4);
        t_test;
        t_rom;
        t_scr;
        t_brk;
        t_pf;
        test_done;
    end
endmodule
